// ---- include/nvws_chk_if.sv ----
// Interface between sequencer and protection checker
`timescale 1ns/100ps
interface nvws_chk_if import nvws_pkg::*; ();
	logic          req;
	logic          wr;
	logic          bypass;
	logic          ee_unlock;
	logic          block;
	logic [AW-1:0] tgt_addr;
	logic [AW-1:0] fetch_addr;
	logic [DW-1:0] apr;
	logic [DW-1:0] wpr;
	modport chk (input req, wr, bypass, ee_unlock, tgt_addr, fetch_addr, apr, wpr, output block);
	modport user (output req, wr, bypass, ee_unlock, tgt_addr, fetch_addr, apr, wpr, input block);
endinterface

// ---- include/nvws_pkg.sv ----
// Constants, types and helpers of the nonvolatile write sequencer
// Operation
// - Clearing selection before start discards latched operands
// - Page operations keep only the last page
// - Operand counts limited per operation type
// - Erase suspend acts from its select bit
// - Protections forced on in reset, then loaded
// - Set protection refused from flash or test memory
// - Test memory region never writable
// - Four protection bytes at consecutive addresses
// - Protection bytes are one-time programmable
// - Main flash access lock by fetch source
// - Test memory access lock by fetch source
// - Emulated memory access lock by fetch source
// - External fetches locked out of internal memories
// - Wrong passwords burn attempt bits, then disable
// - First password write clears test mode disable
// - Matching password clears password ok bit
// - Test memory write lock lifted only by test mode, and only for OTP and protection bytes
// - Emulated write lock lifted by set protection
// - Reading write protection restores the emulated write lock
// - Memory under write reads as all ones
// - Write error flag set by hardware, software clears
package nvws_pkg;
	localparam int AW          = 24;
	localparam int DW          = 8;
	localparam int LATCH_DEPTH = 16;
	localparam int CNT_W       = 5;
	localparam int PAGE_LSB    = 4;
	localparam logic [AW-1:0] FL_HI    = 24'h03_ffff;
	localparam logic [AW-1:0] RAM_LO   = 24'h20_0000;
	localparam logic [AW-1:0] RAM_HI   = 24'h20_1fff;
	localparam logic [AW-1:0] EE_LO    = 24'h22_0000;
	localparam logic [AW-1:0] EE_HI    = 24'h22_03ff;
	localparam logic [AW-1:0] FCR_ADDR = 24'h22_4000;
	localparam logic [AW-1:0] ECR_ADDR = 24'h22_4001;
	localparam logic [AW-1:0] STS_ADDR = 24'h22_4002;
	localparam logic [AW-1:0] TM_LO    = 24'h23_0000;
	localparam logic [AW-1:0] TM_HI    = 24'h23_1f7f;
	localparam logic [AW-1:0] OTP_HI   = 24'h23_1ffb;
	localparam logic [AW-1:0] APR_ADDR = 24'h23_1ffc;
	localparam logic [AW-1:0] WPR_ADDR = 24'h23_1ffd;
	localparam logic [AW-1:0] PWL_ADDR = 24'h23_1ffe;
	localparam logic [AW-1:0] PWH_ADDR = 24'h23_1fff;
	localparam int B_BYTE = 0, B_PAGE = 1, B_SECT = 2, B_SUSP = 3;
	localparam int B_CHIP = 4, B_SET_PROTECTION_SELECT = 5, B_START = 7;
	localparam int E_CHIP = 5, E_PAGE = 6, B_ERR = 7;
	localparam int A_MAIN = 6, A_TM = 5, A_EE = 4, A_EXT = 3, PWT_MSB = 2;
	localparam int W_TEST_MODE_DISABLE = 7, W_PASSWORD_OK = 6, W_TM = 5, W_EE = 4;
	localparam logic [DW-1:0] START_MASK  = 8'h80;
	localparam logic [DW-1:0] SEL_MASK    = 8'h7f;
	localparam logic [DW-1:0] APR_USER    = 8'h78;
	localparam logic [DW-1:0] WPR_USER    = 8'h3f;
	localparam logic [DW-1:0] SET_PROTECTION_SELECT_ALL_ON = 8'h00;
	localparam logic [DW-1:0] BYTE_ONES   = 8'hff;
	localparam logic [CNT_W-1:0] LIM_BYTE = 5'h01;
	localparam logic [CNT_W-1:0] LIM_PAGE = 5'h10;
	localparam logic [CNT_W-1:0] LIM_FOUR = 5'h04;
	localparam int CLK_NS   = 40;
	localparam int SUSP_NS  = 15000;
	localparam int SUSP_CYC = SUSP_NS / CLK_NS;
	localparam int SUSP_W   = $clog2(SUSP_CYC + 1);

	typedef enum logic [2:0] {RG_FLASH, RG_TEST, RG_OTP, RG_PREG, RG_EE, RG_RAM, RG_EXT} nvws_region_t;
	typedef enum logic [2:0] {OP_NONE, OP_BYTE, OP_PAGE, OP_SECT, OP_CHIP, OP_SET_PROTECTION_SELECT, OP_PAGE_UPDATE_SELECT,
		OP_EMUL_CHIP_ERASE_SELECT} nvws_op_t;

	function automatic nvws_region_t region_of(input logic [AW-1:0] a);
		if (a <= FL_HI) return RG_FLASH;
		else if (a >= TM_LO && a <= TM_HI) return RG_TEST;
		else if (a > TM_HI && a <= OTP_HI) return RG_OTP;
		else if (a >= APR_ADDR && a <= PWH_ADDR) return RG_PREG;
		else if (a >= EE_LO && a <= EE_HI) return RG_EE;
		else if (a >= RAM_LO && a <= RAM_HI) return RG_RAM;
		else return RG_EXT;
	endfunction

	function automatic nvws_op_t op_of(input logic [DW-1:0] f, input logic [DW-1:0] e);
		if (f[B_BYTE]) return OP_BYTE;
		else if (f[B_PAGE]) return OP_PAGE;
		else if (f[B_SECT]) return OP_SECT;
		else if (f[B_CHIP]) return OP_CHIP;
		else if (f[B_SET_PROTECTION_SELECT]) return OP_SET_PROTECTION_SELECT;
		else if (e[E_PAGE]) return OP_PAGE_UPDATE_SELECT;
		else if (e[E_CHIP]) return OP_EMUL_CHIP_ERASE_SELECT;
		else return OP_NONE;
	endfunction

	function automatic logic [CNT_W-1:0] lim_of(input nvws_op_t op);
		case (op)
			OP_BYTE: return LIM_BYTE;
			OP_PAGE, OP_PAGE_UPDATE_SELECT: return LIM_PAGE;
			OP_SECT, OP_SET_PROTECTION_SELECT: return LIM_FOUR;
			default: return '0;
		endcase
	endfunction
endpackage

// ---- logic/nvws_chk.sv ----
// Access and write protection checker for operand accesses
`timescale 1ns/100ps
module nvws_chk import nvws_pkg::*; (
	input wire logic clock,
	input wire logic rstn,
	nvws_chk_if.chk  c
);
	nvws_region_t tgt;
	nvws_region_t src;
	logic         tgt_tm;
	logic         acc_blk;
	logic         wr_blk;

	always_comb begin
		tgt = region_of(c.tgt_addr);
		src = region_of(c.fetch_addr);
		tgt_tm = (tgt == RG_TEST) || (tgt == RG_OTP) || (tgt == RG_PREG);
		acc_blk = 1'b0;
		wr_blk = 1'b0;
		if (!c.apr[A_MAIN] && tgt == RG_FLASH && src != RG_TEST && src != RG_FLASH) begin
			acc_blk = 1'b1;
		end
		if (!c.apr[A_TM] && tgt_tm && src != RG_TEST && src != RG_OTP) begin
			acc_blk = 1'b1;
		end
		if (!c.apr[A_EE] && tgt == RG_EE && src != RG_TEST && src != RG_FLASH && src != RG_EE) begin
			acc_blk = 1'b1;
		end
		if (!c.apr[A_EXT] && src == RG_EXT && tgt != RG_EXT) begin
			acc_blk = 1'b1;
		end
		if (c.wr && !c.wpr[W_TM] && tgt_tm) begin
			wr_blk = 1'b1;
		end
		if (c.wr && !c.wpr[W_EE] && !c.ee_unlock && tgt == RG_EE) begin
			wr_blk = 1'b1;
		end
		// Test memory stays write-locked even in test mode
		c.block = c.req && ((c.wr && tgt == RG_TEST) || (!c.bypass && (acc_blk || wr_blk)));
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	tm_write_a: assert property (
		c.req && c.wr && region_of(c.tgt_addr) == RG_TEST |-> c.block)
		else $error("Test memory write not blocked");
	ext_fetch_a: assert property (
		c.req && !c.bypass && !c.apr[A_EXT] && region_of(c.fetch_addr) == RG_EXT
		&& region_of(c.tgt_addr) == RG_RAM |-> c.block)
		else $error("External fetch reached internal RAM");
	tm_wlock_a: assert property (
		c.req && c.wr && !c.bypass && !c.wpr[W_TM] && region_of(c.tgt_addr) == RG_PREG |-> c.block)
		else $error("Protection register write passed the write lock");
endmodule

// ---- logic/nvws_top.sv ----
// Flash and emulated memory write sequencer with protection registers
`timescale 1ns/100ps
module nvws_top import nvws_pkg::*; #(
	parameter int LATCH_MAX = LATCH_DEPTH
) (
	input  wire logic          clock,
	input  wire logic          rstn,
	input  wire logic          cpu_req,
	input  wire logic          cpu_wr,
	input  wire logic [AW-1:0] cpu_addr,
	input  wire logic [DW-1:0] cpu_wdata,
	input  wire logic [AW-1:0] cpu_fetch_addr,
	input  wire logic          test_mode_req,
	input  wire logic [DW-1:0] nv_apr_in,
	input  wire logic [DW-1:0] nv_wpr_in,
	input  wire logic [DW-1:0] nv_pwl_in,
	input  wire logic [DW-1:0] nv_pwh_in,
	input  wire logic          mem_done,
	input  wire logic          mem_err,
	output logic      [DW-1:0] cpu_rdata,
	output logic               cpu_rsel,
	output logic               cpu_blocked,
	output logic               mem_wr,
	output nvws_op_t           mem_op,
	output logic      [AW-1:0] mem_addr,
	output logic      [DW-1:0] mem_data,
	output logic               mem_suspend,
	output logic               main_busy,
	output logic               emul_busy,
	output logic               test_mode_en
);
	localparam int IDX_W = $clog2(LATCH_MAX);

	typedef enum logic [2:0] {ST_INIT, ST_IDLE, ST_ISSUE, ST_WAIT, ST_SUSP} nvws_state_t;

	nvws_state_t       state_r, state_nxt;
	nvws_op_t          op_r, op_nxt, new_op;
	logic [DW-1:0]     fcr_r, fcr_nxt, ecr_r, ecr_nxt;
	logic [DW-1:0]     apr_r, apr_nxt, wpr_r, wpr_nxt;
	logic [DW-1:0]     pwl_r, pwl_nxt, pwh_r, pwh_nxt;
	logic [DW-1:0]     ctl_old, ctl_new, ed;
	logic [AW-1:0]     ea;
	logic [CNT_W-1:0]  cnt_r, cnt_nxt, idx_r, idx_nxt;
	logic [AW-1-PAGE_LSB:0] page_r, page_nxt;
	logic [SUSP_W-1:0] susp_r, susp_nxt;
	logic              err_r, err_nxt, ee_unlock_r, eeu_nxt;
	logic              pw_seen_r, seen_nxt, pw_bad_r, bad_nxt;
	logic [DW-1:0]     rdata_nxt;
	logic              rsel_nxt, blk_nxt, mwr_nxt, msusp_nxt, mbusy_nxt, ebusy_nxt, tmen_nxt;
	logic [AW-1:0]     maddr_nxt;
	logic [DW-1:0]     mdata_nxt;
	logic              rd_ok, wr_ok, ctl_wr, set_protection_select_src_ok, lat_we, last, busy_any;
	logic              tm_s1, tm_s2, tm_s3, tm_q;
	logic [AW-1:0]     ent_addr_m [LATCH_MAX];
	logic [DW-1:0]     ent_data_m [LATCH_MAX];

	nvws_chk_if chk_if ();

	// ****************************************
	// Protection checker
	// ****************************************
	assign chk_if.req        = cpu_req;
	assign chk_if.wr         = cpu_wr;
	assign chk_if.tgt_addr   = cpu_addr;
	assign chk_if.fetch_addr = cpu_fetch_addr;
	assign chk_if.apr        = apr_r;
	assign chk_if.wpr        = wpr_r;
	assign chk_if.ee_unlock  = ee_unlock_r;
	assign chk_if.bypass     = test_mode_en;

	nvws_chk u_chk (
		.clock (clock),
		.rstn  (rstn),
		.c     (chk_if.chk)
	);

	assign rd_ok       = cpu_req && !cpu_wr && !chk_if.block;
	assign wr_ok       = cpu_req && cpu_wr && !chk_if.block;
	assign ctl_wr      = wr_ok && (cpu_addr == FCR_ADDR || cpu_addr == ECR_ADDR);
	assign set_protection_select_src_ok = region_of(cpu_fetch_addr) != RG_FLASH && region_of(cpu_fetch_addr) != RG_TEST;

	// ****************************************
	// Test mode request synchroniser
	// ****************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tm_s1 <= 1'b0;
			tm_s2 <= 1'b0;
			tm_s3 <= 1'b0;
			tm_q  <= 1'b0;
		end else begin
			tm_s1 <= test_mode_req;
			tm_s2 <= tm_s1;
			tm_s3 <= tm_s2;
			tm_q  <= (tm_s2 == tm_s3) ? tm_s3 : tm_q;
		end
	end

	// ****************************************
	// Operand latch array
	// ****************************************
	always_ff @(posedge clock) begin
		if (lat_we) begin
			ent_addr_m[cnt_r[IDX_W-1:0]] <= cpu_addr;
			ent_data_m[cnt_r[IDX_W-1:0]] <= cpu_wdata;
		end
	end

	// ****************************************
	// Sequencer next state
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		op_nxt    = op_r;
		fcr_nxt   = fcr_r;
		ecr_nxt   = ecr_r;
		err_nxt   = err_r;
		cnt_nxt   = cnt_r;
		idx_nxt   = idx_r;
		page_nxt  = page_r;
		apr_nxt   = apr_r;
		wpr_nxt   = wpr_r;
		pwl_nxt   = pwl_r;
		pwh_nxt   = pwh_r;
		eeu_nxt   = ee_unlock_r;
		seen_nxt  = pw_seen_r;
		bad_nxt   = pw_bad_r;
		susp_nxt  = susp_r;
		rdata_nxt = BYTE_ONES;
		rsel_nxt  = 1'b0;
		mwr_nxt   = 1'b0;
		msusp_nxt = 1'b0;
		maddr_nxt = mem_addr;
		mdata_nxt = mem_data;
		lat_we    = 1'b0;
		last      = 1'b0;
		ctl_old   = (cpu_addr == FCR_ADDR) ? fcr_r : ecr_r;
		ctl_new   = cpu_wdata & ~START_MASK;
		new_op    = (cpu_addr == FCR_ADDR) ? op_of(ctl_new, ecr_r) : op_of(fcr_r, ctl_new);
		ea        = ent_addr_m[idx_r[IDX_W-1:0]];
		ed        = ent_data_m[idx_r[IDX_W-1:0]];
		blk_nxt   = cpu_req && chk_if.block;
		if (wr_ok && cpu_addr == STS_ADDR && !cpu_wdata[B_ERR]) begin
			err_nxt = 1'b0;
		end
		if (rd_ok) begin
			rsel_nxt = 1'b1;
			if (cpu_addr == FCR_ADDR) begin
				rdata_nxt = fcr_r;
			end else if (cpu_addr == ECR_ADDR) begin
				rdata_nxt = ecr_r;
			end else if (cpu_addr == STS_ADDR) begin
				rdata_nxt = {err_r, 7'h00};
			end else if (cpu_addr == APR_ADDR) begin
				rdata_nxt = apr_r;
			end else if (cpu_addr == WPR_ADDR) begin
				rdata_nxt = wpr_r;
				eeu_nxt = 1'b0;
			end else if (cpu_addr == PWL_ADDR || cpu_addr == PWH_ADDR) begin
				rdata_nxt = BYTE_ONES;
			end else if (main_busy && region_of(cpu_addr) == RG_FLASH) begin
				rdata_nxt = BYTE_ONES;
			end else if (emul_busy && region_of(cpu_addr) == RG_EE) begin
				rdata_nxt = BYTE_ONES;
			end else begin
				rsel_nxt = 1'b0;
			end
		end
		if (blk_nxt) begin
			rsel_nxt = 1'b1;
		end
		case (state_r)
			ST_INIT: begin
				apr_nxt = nv_apr_in;
				wpr_nxt = nv_wpr_in;
				pwl_nxt = nv_pwl_in;
				pwh_nxt = nv_pwh_in;
				state_nxt = ST_IDLE;
			end
			ST_IDLE: begin
				if (ctl_wr) begin
					if (|(ctl_old & ~ctl_new & SEL_MASK)) begin
						cnt_nxt = '0;
					end
					if (cpu_addr == FCR_ADDR) begin
						fcr_nxt = ctl_new;
					end else begin
						ecr_nxt = ctl_new;
					end
					if (cpu_wdata[B_START] && new_op == OP_SET_PROTECTION_SELECT && !set_protection_select_src_ok) begin
						err_nxt = 1'b1;
						fcr_nxt = '0;
						cnt_nxt = '0;
					end else if (cpu_wdata[B_START] && new_op != OP_NONE && (cnt_nxt != '0
						|| new_op == OP_CHIP || new_op == OP_EMUL_CHIP_ERASE_SELECT)) begin
						if (cpu_addr == FCR_ADDR) begin
							fcr_nxt[B_START] = 1'b1;
						end else begin
							ecr_nxt[B_START] = 1'b1;
						end
						op_nxt = new_op;
						idx_nxt = '0;
						state_nxt = ST_ISSUE;
						if (new_op == OP_SET_PROTECTION_SELECT) begin
							eeu_nxt = 1'b0;
							seen_nxt = 1'b0;
							bad_nxt = 1'b0;
						end
					end
				end else if (wr_ok && op_of(fcr_r, ecr_r) != OP_NONE && cnt_r < lim_of(op_of(fcr_r, ecr_r))
					&& (region_of(cpu_addr) == RG_FLASH && op_of(fcr_r, ecr_r) <= OP_SECT
					|| region_of(cpu_addr) == RG_EE && op_of(fcr_r, ecr_r) == OP_PAGE_UPDATE_SELECT
					|| region_of(cpu_addr) == RG_PREG && op_of(fcr_r, ecr_r) == OP_SET_PROTECTION_SELECT)) begin
					lat_we = 1'b1;
					cnt_nxt = CNT_W'(cnt_r + 5'h01);
					page_nxt = cpu_addr[AW-1:PAGE_LSB];
				end
			end
			ST_ISSUE: begin
				mwr_nxt = 1'b1;
				mdata_nxt = ed;
				maddr_nxt = (op_r == OP_PAGE || op_r == OP_PAGE_UPDATE_SELECT) ? {page_r, ea[PAGE_LSB-1:0]} : ea;
				if (op_r == OP_CHIP || op_r == OP_EMUL_CHIP_ERASE_SELECT) begin
					maddr_nxt = '0;
				end
				if (op_r == OP_SET_PROTECTION_SELECT) begin
					if (ea == APR_ADDR) begin
						apr_nxt = apr_r & (ed | ~APR_USER);
					end else if (ea == WPR_ADDR) begin
						wpr_nxt = wpr_r & (ed | ~WPR_USER);
						eeu_nxt = ed[W_EE];
					end else if (ea == PWL_ADDR || ea == PWH_ADDR) begin
						seen_nxt = 1'b1;
						if (wpr_r[W_TEST_MODE_DISABLE] && ea == PWL_ADDR) begin
							pwl_nxt = pwl_r & ed;
						end else if (wpr_r[W_TEST_MODE_DISABLE]) begin
							pwh_nxt = pwh_r & ed;
						end else if (ed != ((ea == PWL_ADDR) ? pwl_r : pwh_r)) begin
							bad_nxt = 1'b1;
						end
					end
				end
				last = (op_r == OP_CHIP || op_r == OP_EMUL_CHIP_ERASE_SELECT || idx_r == CNT_W'(cnt_r - 5'h01));
				idx_nxt = CNT_W'(idx_r + 5'h01);
				if (last) begin
					state_nxt = ST_WAIT;
					if (op_r == OP_SET_PROTECTION_SELECT && seen_nxt) begin
						if (wpr_r[W_TEST_MODE_DISABLE]) begin
							wpr_nxt[W_TEST_MODE_DISABLE] = 1'b0;
						end else if (bad_nxt) begin
							apr_nxt[PWT_MSB:0] = apr_nxt[PWT_MSB:0] & (apr_nxt[PWT_MSB:0] - 3'h1);
						end else begin
							wpr_nxt[W_PASSWORD_OK] = 1'b0;
						end
					end
				end
			end
			ST_WAIT: begin
				if (ctl_wr && cpu_addr == FCR_ADDR && cpu_wdata[B_SUSP] && op_r == OP_SECT) begin
					msusp_nxt = 1'b1;
					susp_nxt = '0;
					fcr_nxt[B_SUSP] = 1'b1;
					state_nxt = ST_SUSP;
				end else if (mem_done) begin
					if (op_r == OP_PAGE_UPDATE_SELECT || op_r == OP_EMUL_CHIP_ERASE_SELECT) begin
						ecr_nxt = '0;
					end else begin
						fcr_nxt = '0;
					end
					cnt_nxt = '0;
					op_nxt = OP_NONE;
					state_nxt = ST_IDLE;
				end
			end
			ST_SUSP: begin
				susp_nxt = SUSP_W'(susp_r + 1'b1);
				if (susp_r == SUSP_W'(SUSP_CYC - 1)) begin
					fcr_nxt = '0;
					cnt_nxt = '0;
					op_nxt = OP_NONE;
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		if (state_r == ST_WAIT && mem_done && mem_err) begin
			err_nxt = 1'b1;
		end
		busy_any = state_nxt == ST_ISSUE || state_nxt == ST_WAIT || state_nxt == ST_SUSP;
		ebusy_nxt = busy_any && (op_nxt == OP_PAGE_UPDATE_SELECT || op_nxt == OP_EMUL_CHIP_ERASE_SELECT);
		mbusy_nxt = busy_any && !ebusy_nxt;
		tmen_nxt = tm_q && (wpr_r[W_TEST_MODE_DISABLE] || (!wpr_r[W_PASSWORD_OK] && |apr_r[PWT_MSB:0]));
	end

	// ****************************************
	// Sequencer registers
	// ****************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_r      <= ST_INIT;
			op_r         <= OP_NONE;
			fcr_r        <= '0;
			ecr_r        <= '0;
			err_r        <= 1'b0;
			cnt_r        <= '0;
			idx_r        <= '0;
			page_r       <= '0;
			apr_r        <= SET_PROTECTION_SELECT_ALL_ON;
			wpr_r        <= SET_PROTECTION_SELECT_ALL_ON;
			pwl_r        <= '0;
			pwh_r        <= '0;
			ee_unlock_r  <= 1'b0;
			pw_seen_r    <= 1'b0;
			pw_bad_r     <= 1'b0;
			susp_r       <= '0;
			cpu_rdata    <= BYTE_ONES;
			cpu_rsel     <= 1'b0;
			cpu_blocked  <= 1'b0;
			mem_wr       <= 1'b0;
			mem_op       <= OP_NONE;
			mem_addr     <= '0;
			mem_data     <= '0;
			mem_suspend  <= 1'b0;
			main_busy    <= 1'b0;
			emul_busy    <= 1'b0;
			test_mode_en <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			op_r         <= op_nxt;
			fcr_r        <= fcr_nxt;
			ecr_r        <= ecr_nxt;
			err_r        <= err_nxt;
			cnt_r        <= cnt_nxt;
			idx_r        <= idx_nxt;
			page_r       <= page_nxt;
			apr_r        <= apr_nxt;
			wpr_r        <= wpr_nxt;
			pwl_r        <= pwl_nxt;
			pwh_r        <= pwh_nxt;
			ee_unlock_r  <= eeu_nxt;
			pw_seen_r    <= seen_nxt;
			pw_bad_r     <= bad_nxt;
			susp_r       <= susp_nxt;
			cpu_rdata    <= rdata_nxt;
			cpu_rsel     <= rsel_nxt;
			cpu_blocked  <= blk_nxt;
			mem_wr       <= mwr_nxt;
			mem_op       <= op_nxt;
			mem_addr     <= maddr_nxt;
			mem_data     <= mdata_nxt;
			mem_suspend  <= msusp_nxt;
			main_busy    <= mbusy_nxt;
			emul_busy    <= ebusy_nxt;
			test_mode_en <= tmen_nxt;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	cancel_clear_a: assert property (
		state_r == ST_IDLE && ctl_wr && !cpu_wdata[B_START] && |(ctl_old & ~ctl_new & SEL_MASK) |=> cnt_r == '0)
		else $error("Cancelled operation kept operands");
	start_noop_a: assert property (
		state_r == ST_IDLE && ctl_wr && cpu_wdata[B_START] && new_op == OP_NONE
		|=> state_r == ST_IDLE && $stable(cnt_r))
		else $error("Start without selection changed state");
	init_on_a: assert property (
		state_r == ST_INIT |-> apr_r == SET_PROTECTION_SELECT_ALL_ON && wpr_r == SET_PROTECTION_SELECT_ALL_ON)
		else $error("Protections not forced on before load");
	otp_once_a: assert property (
		$past(state_r) != ST_INIT |-> (apr_r & ~$past(apr_r) & APR_USER) == 8'h00)
		else $error("Access protection bit returned to one");
	busy_read_a: assert property (
		rd_ok && main_busy && region_of(cpu_addr) == RG_FLASH |=> cpu_rsel && cpu_rdata == BYTE_ONES)
		else $error("Busy flash read returned stored data");
	err_flag_a: assert property (
		state_r == ST_WAIT && mem_done && mem_err |=> err_r ##1 err_r || $past(wr_ok))
		else $error("Write error flag not set");
	set_protection_select_src_a: assert property (
		state_r == ST_IDLE && ctl_wr && cpu_wdata[B_START] && new_op == OP_SET_PROTECTION_SELECT && !set_protection_select_src_ok
		|=> state_r == ST_IDLE && err_r)
		else $error("Set protection accepted from flash fetch");
	rd_wpr_a: assert property (
		rd_ok && cpu_addr == WPR_ADDR && state_r != ST_ISSUE |=> !ee_unlock_r)
		else $error("Write protection read did not restore lock");
	page_keep_a: assert property (
		state_r == ST_ISSUE && op_r == OP_PAGE |=> mem_wr && mem_addr[AW-1:PAGE_LSB] == $past(page_r))
		else $error("Page program left the kept page");
	susp_hold_a: assert property (
		state_r == ST_WAIT && ctl_wr && cpu_addr == FCR_ADDR && cpu_wdata[B_SUSP] && op_r == OP_SECT
		|=> mem_suspend ##0 (state_r == ST_SUSP && main_busy) [*8])
		else $error("Erase suspend did not take effect");

	set_protection_select_run_c: cover property (state_r == ST_ISSUE && op_r == OP_SET_PROTECTION_SELECT);
	suspend_c: cover property (state_r == ST_SUSP ##1 state_r == ST_IDLE);
	cancel_c: cover property (state_r == ST_IDLE && ctl_wr && cnt_r != '0 && |(ctl_old & ~ctl_new & SEL_MASK));
	pw_fail_c: cover property (state_r == ST_ISSUE && last && pw_bad_r);
endmodule

// ---- testbench/nvws_array_model.sv ----
// Behavioural model of the flash array behind the sequencer
`timescale 1ns/100ps
module nvws_array_model (
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic       mem_wr,
	input  wire logic       busy,
	input  wire logic       err_cmd,
	input  wire logic [7:0] dly,
	output logic            mem_done,
	output logic            mem_err
);
	logic [7:0] cnt_r;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) cnt_r <= '0;
		else if (mem_wr || !busy || mem_done) cnt_r <= '0;
		else cnt_r <= cnt_r + 8'h01;
	end
	// Done after a chosen delay, so fast and slow arrays both occur
	assign mem_done = busy && (cnt_r == dly);
	assign mem_err  = mem_done && err_cmd;
endmodule

// ---- testbench/tb_nvws_top.sv ----
// Self-checking testbench of the write sequencer
`timescale 1ns/100ps
module tb_nvws_top import nvws_pkg::*; ;
	logic clock, rstn, req, wr, done, merr, rsel, blk, mwr, susp, mb, eb, tme, perr, tmr;
	logic [AW-1:0] addr, faddr, maddr;
	logic [DW-1:0] wdata, rdata, mdata, rd, pdly;
	logic rs, bk;
	nvws_op_t op;
	logic [AW-1:0] wa[$];
	logic [DW-1:0] wd[$];
	int err_total, tests_run, i;
	nvws_top u_dut (.clock(clock), .rstn(rstn), .cpu_req(req), .cpu_wr(wr), .cpu_addr(addr),
		.cpu_wdata(wdata), .cpu_fetch_addr(faddr), .test_mode_req(tmr), .nv_apr_in(8'hff),
		.nv_wpr_in(8'hff), .nv_pwl_in(8'hff), .nv_pwh_in(8'hff), .mem_done(done), .mem_err(merr),
		.cpu_rdata(rdata), .cpu_rsel(rsel), .cpu_blocked(blk), .mem_wr(mwr), .mem_op(op),
		.mem_addr(maddr), .mem_data(mdata), .mem_suspend(susp), .main_busy(mb), .emul_busy(eb),
		.test_mode_en(tme));
	nvws_array_model u_arr (.clock(clock), .rstn(rstn), .mem_wr(mwr), .busy(mb | eb),
		.err_cmd(perr), .dly(pdly), .mem_done(done), .mem_err(merr));
	initial begin
		clock = 0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) if (mwr === 1'b1) begin
		wa.push_back(maddr);
		wd.push_back(mdata);
	end
	task automatic chk(input string n, input logic [AW-1:0] s, input logic [AW-1:0] e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	// One access; request is left up for back-to-back use
	task automatic acc(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
		req = 1;
		wr = w;
		addr = a;
		wdata = d;
		@(posedge clock);
		#1;
		rs = rsel;
		rd = rdata;
		bk = blk;
	endtask
	task automatic idle(input int n);
		req = 0;
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wait_idle();
		for (i = 0; i < 400 && (mb | eb) !== 1'b0; i++) idle(1);
		chk("busy", mb | eb, 0);
	endtask
	task automatic s_reset();
		acc(0, APR_ADDR, 0);
		chk("blocked in init", bk, 1);
		acc(0, APR_ADDR, 0);
		chk("access_protection", rd, 8'hff);
		chk("rsel", rs, 1);
		acc(0, WPR_ADDR, 0);
		chk("write_protection", rd, 8'hff);
		acc(0, PWH_ADDR, 0);
		chk("password read", rd, 8'hff);
		acc(0, RAM_LO, 0);
		chk("rsel ram", rs, 0);
		idle(1);
	endtask
	task automatic s_byte();
		wa.delete();
		acc(1, FCR_ADDR, 8'h01);
		acc(1, 24'h00_0100, 8'h5a);
		acc(1, 24'h00_0200, 8'h33);
		acc(1, FCR_ADDR, 8'h81);
		idle(3);
		chk("op", op, OP_BYTE);
		acc(0, 24'h00_0100, 0);
		chk("read under write", rd, 8'hff);
		idle(1);
		wait_idle();
		chk("byte count", wa.size(), 1);
		chk("byte addr", wa[0], 24'h00_0100);
	endtask
	task automatic s_page();
		wa.delete();
		wd.delete();
		pdly = 8'd40;
		acc(1, FCR_ADDR, 8'h02);
		acc(1, 24'h00_0110, 8'h01);
		acc(1, 24'h00_0121, 8'h02);
		acc(1, 24'h00_0132, 8'h03);
		acc(1, FCR_ADDR, 8'h82);
		wait_idle();
		chk("page count", wa.size(), 3);
		for (int k = 0; k < 3; k++) chk("page addr", wa[k], 24'h00_0130 + k);
		for (int k = 0; k < 3; k++) chk("page data", wd[k], k + 1);
	endtask
	task automatic s_cancel();
		wa.delete();
		acc(1, FCR_ADDR, 8'h01);
		acc(1, 24'h00_0100, 8'h11);
		acc(1, FCR_ADDR, 8'h00);
		acc(1, FCR_ADDR, 8'h80);
		acc(1, FCR_ADDR, 8'h01);
		acc(1, FCR_ADDR, 8'h81);
		idle(20);
		chk("cancelled", wa.size(), 0);
		chk("start alone", mb, 0);
	endtask
	task automatic s_set_protection_select();
		acc(1, TM_LO, 8'h00);
		chk("test mem write", bk, 1);
		faddr = 24'h00_0000;
		acc(1, FCR_ADDR, 8'h20);
		acc(1, APR_ADDR, 8'h00);
		acc(1, FCR_ADDR, 8'ha0);
		idle(5);
		faddr = RAM_LO;
		acc(0, STS_ADDR, 0);
		chk("set_protection_select from flash", rd[7], 1);
		acc(1, STS_ADDR, 8'h00);
		acc(0, APR_ADDR, 0);
		chk("apr kept", rd, 8'hff);
		acc(0, STS_ADDR, 0);
		chk("flag cleared", rd[7], 0);
		perr = 1;
		acc(1, FCR_ADDR, 8'h01);
		acc(1, 24'h00_0300, 8'h00);
		acc(1, FCR_ADDR, 8'h81);
		wait_idle();
		acc(0, STS_ADDR, 0);
		chk("write error", rd[7], 1);
		idle(1);
	endtask
	task automatic s_ee();
		wa.delete();
		perr = 0;
		acc(1, ECR_ADDR, 8'h40);
		acc(1, 24'h22_0005, 8'h77);
		acc(1, ECR_ADDR, 8'hc0);
		chk("emul busy", eb, 1);
		chk("main idle", mb, 0);
		chk("op", op, OP_PAGE_UPDATE_SELECT);
		acc(0, 24'h22_0005, 0);
		chk("emul read under write", rd, 8'hff);
		wait_idle();
		chk("emul addr", wa[0], 24'h22_0005);
	endtask
	task automatic s_susp();
		acc(1, FCR_ADDR, 8'h04);
		acc(1, 24'h00_1000, 8'h00);
		acc(1, FCR_ADDR, 8'h84);
		idle(2);
		acc(1, FCR_ADDR, 8'h08);
		chk("suspend pulse", susp, 1);
		chk("busy in suspend", mb, 1);
		wait_idle();
		chk("suspend time", i, SUSP_CYC);
	endtask
	task automatic s_setprot();
		tmr = 1;
		idle(6);
		chk("test mode on", tme, 1);
		acc(1, FCR_ADDR, 8'h20);
		acc(1, APR_ADDR, 8'hb7);
		acc(1, PWL_ADDR, 8'h5a);
		acc(1, PWH_ADDR, 8'ha5);
		acc(1, FCR_ADDR, 8'ha0);
		wait_idle();
		acc(0, APR_ADDR, 0);
		chk("apr set", rd, 8'hb7);
		acc(0, WPR_ADDR, 0);
		chk("test_mode_disable cleared", rd, 8'h7f);
		chk("test mode off", tme, 0);
		acc(0, 24'h00_0100, 0);
		chk("flash locked", bk, 1);
		faddr = 24'h10_0000;
		acc(0, RAM_LO, 0);
		chk("external fetch", bk, 1);
		faddr = RAM_LO;
		acc(1, FCR_ADDR, 8'h20);
		acc(1, PWL_ADDR, 8'h00);
		acc(1, FCR_ADDR, 8'ha0);
		wait_idle();
		acc(0, APR_ADDR, 0);
		chk("attempt burnt", rd, 8'hb6);
		acc(1, FCR_ADDR, 8'h20);
		acc(1, PWL_ADDR, 8'h5a);
		acc(1, PWH_ADDR, 8'ha5);
		acc(1, FCR_ADDR, 8'ha0);
		wait_idle();
		acc(0, WPR_ADDR, 0);
		chk("password ok", rd, 8'h3f);
		chk("test mode back", tme, 1);
		idle(1);
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		{rstn, req, wr, perr, tmr} = 0;
		{addr, wdata} = 0;
		faddr = RAM_LO;
		pdly = 8'd3;
		repeat (8) @(posedge clock);
		#1;
		rstn = 1;
		s_reset();
		s_byte();
		s_page();
		s_cancel();
		s_set_protection_select();
		s_ee();
		s_susp();
		s_setprot();
		test_done();
	end
	initial begin
		repeat (4000) @(posedge clock);
		err_total++;
		test_done();
	end
endmodule
